// ---- tb/sta_mem_model.sv ----
/*
  Core memory partner model for the stack block: a word array that
  answers each held request with a one-cycle ack after some waits.
  Assumes the device holds request, address and data until the ack.
*/
`timescale 1ns/1ns
`default_nettype none
module sta_mem_model (
  input wire logic clk, // Processor clock
  input wire logic rst_n, // Async reset, low
  input wire logic req, // Access held
  input wire logic we, // Write access
  input wire logic [sta_pkg::ADDR_W-1:0] addr, // Word address
  input wire logic [sta_pkg::WORD_W-1:0] wdata, // Write word
  input wire logic [3:0] wait_cycles, // Waits before the ack
  output logic ack, // One-cycle done pulse
  output logic [sta_pkg::WORD_W-1:0] rdata // Read word
);
  logic [sta_pkg::WORD_W-1:0] mem [0:32767]; // Core words
  logic [3:0] waited; // Cycles spent in this access

  // ---------------------------------------------------------------
  // Access engine
  // ---------------------------------------------------------------
  // Plain always: the bench also pokes the array directly
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack <= 1'b0;
      waited <= 4'h0;
      rdata <= 48'h0;
    end
    else if (req && !ack && waited >= wait_cycles)
    begin
      // Answer now; write lands with the ack
      ack <= 1'b1;
      waited <= 4'h0;
      rdata <= mem[addr];
      if (we)
        mem[addr] <= wdata;
    end
    else
    begin
      // Data line garbles outside the ack so late samples fail
      ack <= 1'b0;
      rdata <= ~rdata;
      if (req && !ack)
        waited <= waited + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
/*
  Testbench for the stack top manager: scenario tasks issue commands
  and judge registers, pointer and memory words against hand values.
  Assumes the design package and memory model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic CLOCK = 1'b0; // 10 ns clock
  logic RESET_N = 1'b0; // Reset, low
  logic CMD_VALID = 1'b0; // Command offered
  logic [3:0] CMD_OP = 4'h0; // Command code
  logic [14:0] CMD_ARG = 15'h0000; // Command argument
  logic [3:0] WAIT_CYC = 4'h0; // Memory wait states
  wire logic CMD_READY, MEM_REQ, MEM_WE, MEM_ACK; // Handshakes
  wire logic UPPER_VALID, LOWER_VALID; // Valid flags
  wire logic [14:0] MEM_ADDR, STACK_PTR, WINDOW_BASE; // Addresses
  wire logic [47:0] MEM_WDATA, MEM_RDATA, UPPER_WORD, LOWER_WORD; // Words
  wire logic [47:0] sp = {33'h0, STACK_PTR}; // Pointer, widened
  wire logic [47:0] fl = {46'h0, UPPER_VALID, LOWER_VALID}; // Flags
  localparam logic [47:0] DSC = 48'h8000_0000_0400; // Descriptor
  int failures = 0; // Mismatches
  int cmp_count = 0; // Comparisons

  always #5 CLOCK = ~CLOCK;

  sta_top sta_top_inst (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_OP(CMD_OP),
    .CMD_ARG(CMD_ARG), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
    .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK),
    .MEM_RDATA(MEM_RDATA), .UPPER_WORD(UPPER_WORD),
    .LOWER_WORD(LOWER_WORD), .UPPER_VALID(UPPER_VALID),
    .LOWER_VALID(LOWER_VALID), .STACK_PTR(STACK_PTR),
    .WINDOW_BASE(WINDOW_BASE));

  sta_mem_model sta_mem_model_inst (.clk(CLOCK), .rst_n(RESET_N),
    .req(MEM_REQ), .we(MEM_WE), .addr(MEM_ADDR), .wdata(MEM_WDATA),
    .wait_cycles(WAIT_CYC), .ack(MEM_ACK), .rdata(MEM_RDATA));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Word compare, four-state exact
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for ready at falling edges
  task automatic wait_ready();
    int n;
    n = 0;
    while (CMD_READY !== 1'b1 && n < 300)
    begin
      n++;
      @(negedge CLOCK);
    end
    if (CMD_READY !== 1'b1)
    begin
      failures++;
      results();
    end
  endtask

  // One command: offer, hold until taken, wait for the finish
  task automatic cmd(input logic [3:0] op, input logic [14:0] arg);
    @(negedge CLOCK);
    CMD_VALID = 1'b1;
    CMD_OP = op;
    CMD_ARG = arg;
    wait_ready();
    @(negedge CLOCK);
    CMD_VALID = 1'b0;
    wait_ready();
  endtask

  // Reset held ten cycles
  task automatic do_reset();
    @(negedge CLOCK);
    RESET_N = 1'b0;
    repeat (10) @(negedge CLOCK);
    RESET_N = 1'b1;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Literal pushes up to a spill, then adds with and without fill
  task automatic t_push_add();
    cmd(sta_pkg::OP_SET_S, 15'h0100);
    cmd(sta_pkg::OP_LIT, 15'h03FF);
    chk(UPPER_WORD, 48'h3FF);
    chk(fl, 48'h2);
    cmd(sta_pkg::OP_LIT, 15'h0005);
    chk(LOWER_WORD, 48'h3FF);
    cmd(sta_pkg::OP_LIT, 15'h0007);
    chk(sta_mem_model_inst.mem[15'h0101], 48'h3FF);
    chk(sp, 48'h101);
    chk(UPPER_WORD, 48'h7);
    chk(LOWER_WORD, 48'h5);
    chk(fl, 48'h3);
    cmd(sta_pkg::OP_ADD, 15'h0000);
    chk(LOWER_WORD, 48'hC);
    chk(fl, 48'h1);
    cmd(sta_pkg::OP_ADD, 15'h0000);
    chk(LOWER_WORD, 48'h40B);
    chk(sp, 48'h100);
    $display("push and add test done");
  endtask

  // Double fill from memory, swap, product kept to the low word
  task automatic t_fill_mul();
    do_reset();
    sta_mem_model_inst.mem[15'h0200] = 48'hFFFF_FFFF_FFFF;
    sta_mem_model_inst.mem[15'h01FF] = 48'h2;
    cmd(sta_pkg::OP_SET_S, 15'h0200);
    cmd(sta_pkg::OP_SWAP, 15'h0000);
    chk(UPPER_WORD, 48'h2);
    chk(LOWER_WORD, 48'hFFFF_FFFF_FFFF);
    chk(sp, 48'h1FE);
    chk(fl, 48'h3);
    cmd(sta_pkg::OP_MUL, 15'h0000);
    chk(LOWER_WORD, 48'hFFFF_FFFF_FFFE);
    chk(fl, 48'h1);
    $display("fill and multiply test done");
  endtask

  // Assignment sequence through a slow memory
  task automatic t_store();
    do_reset();
    WAIT_CYC = 4'h3;
    sta_mem_model_inst.mem[15'h0332] = 48'h11;
    sta_mem_model_inst.mem[15'h0345] = 48'h22;
    cmd(sta_pkg::OP_SET_R, 15'h0300);
    cmd(sta_pkg::OP_SET_S, 15'h0010);
    cmd(sta_pkg::OP_ACALL, 15'h0100);
    chk(UPPER_WORD, DSC);
    cmd(sta_pkg::OP_VCALL, 15'h0032);
    chk(UPPER_WORD, 48'h11);
    cmd(sta_pkg::OP_VCALL, 15'h0045);
    chk(sta_mem_model_inst.mem[15'h0011], DSC);
    cmd(sta_pkg::OP_ADD, 15'h0000);
    cmd(sta_pkg::OP_SWAP, 15'h0000);
    chk(UPPER_WORD, DSC);
    chk(LOWER_WORD, 48'h33);
    chk(sp, 48'h10);
    cmd(sta_pkg::OP_STORE, 15'h0000);
    chk(sta_mem_model_inst.mem[15'h0400], 48'h33);
    chk({33'h0, MEM_ADDR}, 48'h400);
    chk(MEM_WDATA, 48'h33);
    chk({46'h0, MEM_REQ, MEM_WE}, 48'h0);
    chk(fl, 48'h0);
    WAIT_CYC = 4'h0;
    $display("store test done");
  endtask

  // Window relative fetch, then idle codes change nothing
  task automatic t_rel();
    do_reset();
    sta_mem_model_inst.mem[15'h0053] = 48'hABC;
    cmd(sta_pkg::OP_SET_F, 15'h0050);
    chk({33'h0, WINDOW_BASE}, 48'h50);
    cmd(sta_pkg::OP_REL, 15'h0003);
    cmd(sta_pkg::OP_NOP, 15'h0000);
    cmd(4'hF, 15'h0000);
    chk(UPPER_WORD, 48'hABC);
    chk(fl, 48'h2);
    $display("relative fetch test done");
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    do_reset();
    chk(fl, 48'h0);
    chk({47'h0, CMD_READY}, 48'h1);
    t_push_add();
    t_fill_mul();
    t_store();
    t_rel();
    results();
  end
endmodule
`default_nettype wire

// ---- verilog/sta_alu.sv ----
/*
  Two-operand arithmetic for the stack block: sum or product of the
  top two words, result registered one cycle after the go pulse.
  Assumes operands stay stable in the go cycle only.
*/
`timescale 1ns/1ns
`default_nettype none
module sta_alu (
  input wire logic clk,                         // Processor clock
  input wire logic rst_n,                       // Async reset, low
  input wire logic go,                          // Start, one cycle
  input wire logic is_mul,                      // Product, else sum
  input wire logic [sta_pkg::WORD_W-1:0] opa,   // Top word
  input wire logic [sta_pkg::WORD_W-1:0] opb,   // Second word
  output logic [sta_pkg::WORD_W-1:0] result     // Registered result
);
  // ---------------------------------------------------------------
  // Arithmetic
  // ---------------------------------------------------------------
  logic [2*sta_pkg::WORD_W-1:0] prod; // Full product
  logic [sta_pkg::WORD_W-1:0] sum;    // Wrapping sum

  // Only the low word is kept; overflow detection is not modelled
  always_comb
  begin
    prod = opa * opb;
    sum = opa + opb;
  end

  // Capture on go so the result is steady for the caller
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      result <= '0;
    else if (go)
    begin
      if (is_mul)
        result <= prod[sta_pkg::WORD_W-1:0];
      else
        result <= sum;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/sta_pkg.sv ----
/*
  Shared constants for the stack top adjust block: widths, command
  codes, descriptor layout, reset values and the sequencer states.
  Assumes a single clock domain and one outstanding memory access.
*/
`default_nettype none
package sta_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int WORD_W = 48; // One full stack word
  localparam int ADDR_W = 15; // Core memory address
  localparam int LIT_W = 10;  // Literal constant field, below 1024
  localparam int OP_W = 4;    // Command code

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_NOP = 4'h0;   // Nothing
  localparam logic [3:0] OP_SET_S = 4'h1; // Load memory-top pointer
  localparam logic [3:0] OP_SET_F = 4'h2; // Load window base
  localparam logic [3:0] OP_SET_R = 4'h3; // Load reference table base
  localparam logic [3:0] OP_LIT = 4'h4;   // literal_syllable
  localparam logic [3:0] OP_VCALL = 4'h5; // value_call_syllable
  localparam logic [3:0] OP_ACALL = 4'h6; // address_call_syllable
  localparam logic [3:0] OP_REL = 4'h7;   // Window relative fetch
  localparam logic [3:0] OP_ADD = 4'h8;   // Add operator
  localparam logic [3:0] OP_MUL = 4'h9;   // Multiply operator
  localparam logic [3:0] OP_SWAP = 4'hA;  // swap_operator
  localparam logic [3:0] OP_STORE = 4'hB; // store_to_descriptor

  // ---------------------------------------------------------------
  // Word layout and reset values
  // ---------------------------------------------------------------
  localparam int ADDRESS_CALL_SYLLABLE_BIT = 47; // Marks a data descriptor word
  localparam logic [14:0] PTR_RESET = 15'h0000; // Pointer registers
  localparam logic [14:0] ONE_ADDR = 15'h0001;  // Pointer step

  // ---------------------------------------------------------------
  // Sequencer states, Gray along the fill and spill paths
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DISP = 3'h1,
    ST_FILL = 3'h3,
    ST_ALU = 3'h2,
    ST_STORE = 3'h6,
    ST_FETCH = 3'h7,
    ST_SPILL = 3'h5
  } sta_state_e;
endpackage
`default_nettype wire

// ---- verilog/sta_top.sv ----
/*
  Stack top manager: keeps the top one or two stack words in the
  upper and lower arithmetic registers, moves words to and from core
  memory, and runs the push syllables and two-operand operators.
  Assumes core memory answers each held request with a one-cycle ack.
*/
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Spill: increment pointer, then write there
// - Stack positions follow the two valid flags
// - Fill: read at pointer, then decrement it
// - Double fill: load lower, move up, reload
// - Two-operand ops wait for both registers
// - Result in lower register, upper emptied
// - Operators touch only top two words
// - Relative fetch at window base plus index
// - Literal pushes ten-bit constant as integer
// - Add leaves only the sum on top
// - Multiply leaves only the product on top
// - Store writes second word at descriptor
// - Swap exchanges the top two words
// - Address call pushes absolute address descriptor
// - Value call pushes referenced memory word
// - Store consumes both value and descriptor
// - Upper flag set exactly when upper valid
// - Lower flag set exactly when lower valid
// - Each register holds one 48-bit word
module sta_top (
  input wire logic CLOCK,                              // 100 MHz
  input wire logic RESET_N,                            // Async, low
  input wire logic CMD_VALID,                          // Command offered
  output logic CMD_READY,                              // Idle, takes cmd
  input wire logic [sta_pkg::OP_W-1:0] CMD_OP,         // Command code
  input wire logic [sta_pkg::ADDR_W-1:0] CMD_ARG,      // Index or value
  output logic MEM_REQ,                                // Access held
  output logic MEM_WE,                                 // Write access
  output logic [sta_pkg::ADDR_W-1:0] MEM_ADDR,         // Word address
  output logic [sta_pkg::WORD_W-1:0] MEM_WDATA,        // Write word
  input wire logic MEM_ACK,                            // Access done
  input wire logic [sta_pkg::WORD_W-1:0] MEM_RDATA,    // Read word
  output logic [sta_pkg::WORD_W-1:0] UPPER_WORD,       // A register
  output logic [sta_pkg::WORD_W-1:0] LOWER_WORD,       // B register
  output logic UPPER_VALID,                            // upper flag
  output logic LOWER_VALID,                            // lower flag
  output logic [sta_pkg::ADDR_W-1:0] STACK_PTR,        // Memory top
  output logic [sta_pkg::ADDR_W-1:0] WINDOW_BASE       // Window base
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Push classes bring a word to the top
  function automatic logic is_push(input logic [3:0] o);
    is_push = (o == sta_pkg::OP_LIT) || (o == sta_pkg::OP_VCALL) ||
              (o == sta_pkg::OP_ACALL) || (o == sta_pkg::OP_REL);
  endfunction

  // Pushes whose word comes from memory
  function automatic logic needs_fetch(input logic [3:0] o);
    needs_fetch = (o == sta_pkg::OP_VCALL) || (o == sta_pkg::OP_REL);
  endfunction

  // Operators on the top two words only
  function automatic logic is_two(input logic [3:0] o);
    is_two = (o == sta_pkg::OP_ADD) || (o == sta_pkg::OP_MUL) ||
             (o == sta_pkg::OP_SWAP) || (o == sta_pkg::OP_STORE);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  sta_pkg::sta_state_e state;      // Sequencer
  sta_pkg::sta_state_e next_state; // Its next value
  logic [3:0] op;                  // Latched command
  logic [14:0] arg;                // Latched argument
  logic [47:0] a;                  // Upper arithmetic register
  logic [47:0] b;                  // Lower arithmetic register
  logic av;                        // Upper valid flag
  logic bv;                        // Lower valid flag
  logic [14:0] s;                  // Memory-top pointer
  logic [14:0] f;                  // Window base
  logic [14:0] r;                  // Reference table base
  logic [47:0] pend;               // Fetched word awaiting push
  logic have;                      // pend is loaded
  logic [47:0] push_word;          // Word to place on top
  logic [47:0] alu_res;            // Sum or product
  logic alu_go;                    // Start arithmetic
  logic both;                      // Both registers valid
  logic mem_done;                  // Access acknowledged

  assign both = av && bv;
  assign mem_done = MEM_REQ && MEM_ACK;

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign CMD_READY = (state == sta_pkg::ST_IDLE);
  assign MEM_REQ = (state == sta_pkg::ST_FETCH) ||
                   (state == sta_pkg::ST_SPILL) ||
                   (state == sta_pkg::ST_FILL) ||
                   (state == sta_pkg::ST_STORE);
  assign MEM_WE = (state == sta_pkg::ST_SPILL) ||
                  (state == sta_pkg::ST_STORE);
  assign UPPER_WORD = a;
  assign LOWER_WORD = b;
  assign UPPER_VALID = av;
  assign LOWER_VALID = bv;
  assign STACK_PTR = s;
  assign WINDOW_BASE = f;

  // ---------------------------------------------------------------
  // Word to push
  // ---------------------------------------------------------------
  // Literal is a zero-extended integer, no memory word needed
  always_comb
  begin
    push_word = '0;
    if (op == sta_pkg::OP_LIT)
      push_word[sta_pkg::LIT_W-1:0] = arg[sta_pkg::LIT_W-1:0];
    else if (op == sta_pkg::OP_ACALL)
    begin
      push_word[sta_pkg::ADDR_W-1:0] = r + arg;
      push_word[sta_pkg::ADDRESS_CALL_SYLLABLE_BIT] = 1'b1;
    end
    else
      push_word = pend;
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // One decision per visit to DISP; fetch, spill and fill steps loop back to it, store goes to IDLE
  always_comb
  begin
    next_state = state;
    case (state)
      sta_pkg::ST_IDLE:
        if (CMD_VALID)
          next_state = sta_pkg::ST_DISP;
      sta_pkg::ST_DISP:
        if (is_push(op))
        begin
          if (needs_fetch(op) && !have)
            next_state = sta_pkg::ST_FETCH;
          else if (both)
            next_state = sta_pkg::ST_SPILL;
          else
            next_state = sta_pkg::ST_IDLE;
        end
        else if (is_two(op))
        begin
          // Adjust until both hold valid words
          if (!both)
          begin
            if (bv)
              next_state = sta_pkg::ST_DISP;
            else
              next_state = sta_pkg::ST_FILL;
          end
          else if (op == sta_pkg::OP_STORE)
            next_state = sta_pkg::ST_STORE;
          else if (op == sta_pkg::OP_SWAP)
            next_state = sta_pkg::ST_IDLE;
          else
            next_state = sta_pkg::ST_ALU;
        end
        else
          next_state = sta_pkg::ST_IDLE;
      sta_pkg::ST_FETCH, sta_pkg::ST_SPILL, sta_pkg::ST_FILL:
        if (MEM_ACK)
          next_state = sta_pkg::ST_DISP;
      sta_pkg::ST_ALU:
        next_state = sta_pkg::ST_IDLE;
      sta_pkg::ST_STORE:
        if (MEM_ACK)
          next_state = sta_pkg::ST_IDLE;
      default:
        next_state = sta_pkg::ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
      state <= sta_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  // Command latch, taken only while idle
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      op <= sta_pkg::OP_NOP;
      arg <= sta_pkg::PTR_RESET;
    end
    else if (CMD_READY && CMD_VALID)
    begin
      op <= CMD_OP;
      arg <= CMD_ARG;
    end
  end

  // ---------------------------------------------------------------
  // Base registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      f <= sta_pkg::PTR_RESET;
      r <= sta_pkg::PTR_RESET;
    end
    else if (state == sta_pkg::ST_DISP)
    begin
      if (op == sta_pkg::OP_SET_F)
        f <= arg;
      if (op == sta_pkg::OP_SET_R)
        r <= arg;
    end
  end

  // Memory-top pointer: up before a spill, down after a fill
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
      s <= sta_pkg::PTR_RESET;
    else if (state == sta_pkg::ST_DISP && op == sta_pkg::OP_SET_S)
      s <= arg;
    else if (state == sta_pkg::ST_DISP &&
             next_state == sta_pkg::ST_SPILL)
      s <= s + sta_pkg::ONE_ADDR;
    else if (state == sta_pkg::ST_FILL && MEM_ACK)
      s <= s - sta_pkg::ONE_ADDR;
  end

  // ---------------------------------------------------------------
  // Memory address and write data
  // ---------------------------------------------------------------
  // Set on entry so they stand unchanged for the whole access
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      MEM_ADDR <= sta_pkg::PTR_RESET;
      MEM_WDATA <= '0;
    end
    else if (state == sta_pkg::ST_DISP)
    begin
      case (next_state)
        sta_pkg::ST_SPILL:
        begin
          MEM_ADDR <= s + sta_pkg::ONE_ADDR;
          MEM_WDATA <= b;
        end
        sta_pkg::ST_FILL:
          MEM_ADDR <= s;
        sta_pkg::ST_FETCH:
          if (op == sta_pkg::OP_REL)
            MEM_ADDR <= f + arg;
          else
            MEM_ADDR <= r + arg;
        sta_pkg::ST_STORE:
        begin
          MEM_ADDR <= a[sta_pkg::ADDR_W-1:0];
          MEM_WDATA <= b;
        end
        default:
          MEM_ADDR <= MEM_ADDR;
      endcase
    end
  end

  // Fetched word for value call and relative access
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pend <= '0;
      have <= 1'b0;
    end
    else if (CMD_READY)
      have <= 1'b0;
    else if (state == sta_pkg::ST_FETCH && MEM_ACK)
    begin
      pend <= MEM_RDATA;
      have <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Arithmetic unit
  // ---------------------------------------------------------------
  assign alu_go = (state == sta_pkg::ST_DISP) &&
                  (next_state == sta_pkg::ST_ALU);

  sta_alu u_alu (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .go(alu_go),
    .is_mul(op == sta_pkg::OP_MUL),
    .opa(a),
    .opb(b),
    .result(alu_res)
  );

  // ---------------------------------------------------------------
  // Stack registers and valid flags
  // ---------------------------------------------------------------
  // Flags move only together with their words, so they never lie
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      a <= '0;
      b <= '0;
      av <= 1'b0;
      bv <= 1'b0;
    end
    else
    begin
      case (state)
        sta_pkg::ST_DISP:
          if (is_push(op) && !both && !(needs_fetch(op) && !have))
          begin
            // Place on top; old top slides down one
            if (av)
            begin
              b <= a;
              bv <= 1'b1;
            end
            a <= push_word;
            av <= 1'b1;
          end
          else if (is_two(op) && !av && bv)
          begin
            a <= b;
            av <= 1'b1;
            bv <= 1'b0;
          end
          else if (op == sta_pkg::OP_SWAP && both)
          begin
            a <= b;
            b <= a;
          end
        sta_pkg::ST_SPILL:
          if (MEM_ACK)
            bv <= 1'b0;
        sta_pkg::ST_FILL:
          if (MEM_ACK)
          begin
            b <= MEM_RDATA;
            bv <= 1'b1;
          end
        sta_pkg::ST_ALU:
        begin
          b <= alu_res;
          bv <= 1'b1;
          av <= 1'b0;
        end
        sta_pkg::ST_STORE:
          if (MEM_ACK)
          begin
            av <= 1'b0;
            bv <= 1'b0;
          end
        default:
          av <= av;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  property p_spill_addr;
    $rose(state == sta_pkg::ST_SPILL) |->
      s == $past(s) + sta_pkg::ONE_ADDR && MEM_ADDR == s && MEM_WE;
  endproperty
  a_spill_addr: assert property (p_spill_addr)
    else $error("spill not at incremented pointer");

  property p_fill_dec;
    state == sta_pkg::ST_FILL && MEM_ACK |=>
      s == $past(s) - sta_pkg::ONE_ADDR && bv && b == $past(MEM_RDATA);
  endproperty
  a_fill_dec: assert property (p_fill_dec)
    else $error("fill did not load and decrement");

  property p_fill_at_top;
    state == sta_pkg::ST_FILL |-> MEM_ADDR == s && !MEM_WE;
  endproperty
  a_fill_at_top: assert property (p_fill_at_top)
    else $error("fill address is not the pointer");

  property p_two_ready;
    state == sta_pkg::ST_ALU || state == sta_pkg::ST_STORE |-> both;
  endproperty
  a_two_ready: assert property (p_two_ready)
    else $error("operator ran without two operands");

  property p_result;
    state == sta_pkg::ST_ALU |=> bv && !av && b == $past(alu_res);
  endproperty
  a_result: assert property (p_result)
    else $error("result not left in lower register");

  property p_store_word;
    state == sta_pkg::ST_STORE |->
      MEM_ADDR == a[sta_pkg::ADDR_W-1:0] && MEM_WDATA == b;
  endproperty
  a_store_word: assert property (p_store_word)
    else $error("store address or data wrong");

  property p_store_empty;
    state == sta_pkg::ST_STORE && MEM_ACK |=> !av && !bv;
  endproperty
  a_store_empty: assert property (p_store_empty)
    else $error("store left words on the stack");

  property p_swap;
    state == sta_pkg::ST_DISP && op == sta_pkg::OP_SWAP && both |=>
      a == $past(b) && b == $past(a) && both;
  endproperty
  a_swap: assert property (p_swap)
    else $error("swap did not exchange words");

  // Lower word stays valid until the spill ack edge clears it
  property p_spill_full;
    state == sta_pkg::ST_SPILL |-> both;
  endproperty
  a_spill_full: assert property (p_spill_full)
    else $error("spill while a register was empty");

  c_add: cover property (state == sta_pkg::ST_ALU &&
                         op == sta_pkg::OP_ADD);
  c_spill: cover property (state == sta_pkg::ST_SPILL && MEM_ACK);
  c_store: cover property (state == sta_pkg::ST_STORE && MEM_ACK);
endmodule
`default_nettype wire
